// ===== include/ldop_pkg.sv
// constants and encodings for the load / output / power instruction group
// assumes a 10-bit instruction word presented once per machine cycle
//
// Function
// - increment y pointer, skip next on wrap
// - load accumulator immediate, chained loads skipped
// - load x and y pointers in one cycle
// - back to back pointer loads: later skipped
// - load 2-bit bank pointer, nothing else
// - no-operation changes only program counter, arm flag and chain state
// - accumulator bit 0 to single-bit port
// - accumulator to port zero or port one
// - accumulator bits 1:0 to port two
// - accumulator or memory nibble, carry kept
// - armed backup entry stops all functions
// - unarmed backup entry acts as no-operation
// - rotate carry and accumulator right by one
package ldop_pkg;
  localparam logic [9:0] OP_NOP = 10'h000;
  localparam logic [9:0] OP_INC_Y = 10'h013;
  localparam logic [9:0] OP_OR_MEM = 10'h019;
  localparam logic [9:0] OP_ROT_RIGHT = 10'h01D;
  localparam logic [9:0] OP_BACKUP_ENTRY = 10'h008;
  localparam logic [9:0] OP_BACKUP_ARM = 10'h02D;
  localparam logic [9:0] OP_WR_BIT_PORT = 10'h21F;
  localparam logic [9:0] OP_WR_PORT0 = 10'h220;
  localparam logic [9:0] OP_WR_PORT1 = 10'h221;
  localparam logic [9:0] OP_WR_PORT2 = 10'h222;
  localparam logic [5:0] OP_LOAD_ACC_HI = 6'h07;
  localparam logic [7:0] OP_LOAD_BANK_HI = 8'h12;
  localparam logic [1:0] OP_LOAD_XY_HI = 2'h3;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam int AVM_ADDR_W = 4;
  // register word offsets (index; byte address is four times it)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_INSTR = 4'h1;
  localparam logic [3:0] REG_MEM = 4'h2;
  localparam logic [3:0] REG_STATE = 4'h3;
  localparam logic [3:0] REG_PORTS = 4'h4;
  localparam logic [3:0] REG_PC = 4'h5;
  typedef enum logic [1:0] {
    CHAIN_NONE,
    CHAIN_ACC,
    CHAIN_XY
  } chain_t;
endpackage

// ===== rtl/ldop_decode.sv
// combinational decode of one instruction word into its group strobes
// assumes the word is stable for the whole cycle it is decoded in
`timescale 1ns/1ps
`default_nettype none
module ldop_decode
  import ldop_pkg::*;
(
  input wire logic [9:0] word,
  output logic is_nop,
  output logic is_inc_y,
  output logic is_or_mem,
  output logic is_rot,
  output logic is_entry,
  output logic is_arm,
  output logic is_wr_bit,
  output logic is_wr_p0,
  output logic is_wr_p1,
  output logic is_wr_p2,
  output logic is_load_acc,
  output logic is_load_bank,
  output logic is_load_xy
);
  assign is_nop = word == OP_NOP;
  assign is_inc_y = word == OP_INC_Y;
  assign is_or_mem = word == OP_OR_MEM;
  assign is_rot = word == OP_ROT_RIGHT;
  assign is_entry = word == OP_BACKUP_ENTRY;
  assign is_arm = word == OP_BACKUP_ARM;
  assign is_wr_bit = word == OP_WR_BIT_PORT;
  assign is_wr_p0 = word == OP_WR_PORT0;
  assign is_wr_p1 = word == OP_WR_PORT1;
  assign is_wr_p2 = word == OP_WR_PORT2;
  assign is_load_acc = word[9:4] == OP_LOAD_ACC_HI;
  assign is_load_bank = word[9:2] == OP_LOAD_BANK_HI;
  assign is_load_xy = word[9:8] == OP_LOAD_XY_HI;
endmodule
`default_nettype wire

// ===== rtl/ldop_core.sv
// executes the load, output and power instruction group of a 4-bit core
// software writes an instruction word and a memory nibble over Avalon-MM,
// then writes the step register; the word executes in one machine cycle
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module ldop_core
  import ldop_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [ldop_pkg::AVM_ADDR_W-1:0] AVM_ADDRESS,
  input wire logic AVM_READ,
  input wire logic AVM_WRITE,
  input wire logic [31:0] AVM_WRITEDATA,
  input wire logic [3:0] AVM_BYTEENABLE,
  output logic [31:0] AVM_READDATA,
  output logic AVM_WAITREQUEST,
  output logic [3:0] PORT_ZERO_PINS,
  output logic [3:0] PORT_ONE_PINS,
  output logic [1:0] PORT_TWO_PINS,
  output logic SINGLE_BIT_PORT,
  output logic BACKUP_STATE
);
  import ldop_pkg::*;

  logic [9:0] instr;
  logic [3:0] mem_nibble;
  logic [3:0] accum;
  logic carry_flag;
  logic [3:0] ptr_x;
  logic [3:0] ptr_y;
  logic [1:0] ptr_z;
  logic [11:0] pc;
  logic skip_next;
  logic armed;
  chain_t chain;
  logic [3:0] port0;
  logic [3:0] port1;
  logic [1:0] port2;
  logic bit_port;
  logic backup;
  logic waitreq;
  logic [31:0] rdata;

  logic d_nop, d_inc_y, d_or, d_rot, d_entry, d_arm, d_wbit, d_wp0, d_wp1, d_wp2, d_la, d_lz, d_lxy;

  ldop_decode u_dec (
    .word(instr),
    .is_nop(d_nop),
    .is_inc_y(d_inc_y),
    .is_or_mem(d_or),
    .is_rot(d_rot),
    .is_entry(d_entry),
    .is_arm(d_arm),
    .is_wr_bit(d_wbit),
    .is_wr_p0(d_wp0),
    .is_wr_p1(d_wp1),
    .is_wr_p2(d_wp2),
    .is_load_acc(d_la),
    .is_load_bank(d_lz),
    .is_load_xy(d_lxy)
  );

  // bus access: one wait cycle, answered on the second edge
  // waitrequest is kept as its own flop so the pin never sees decode glitches
  wire ack = ~waitreq;
  wire req = (AVM_READ | AVM_WRITE) & ~ack;
  wire wr_hit = AVM_WRITE & ack;
  wire lo_en = AVM_BYTEENABLE[0];
  wire hi_en = AVM_BYTEENABLE[1];
  wire wr_instr = wr_hit & (AVM_ADDRESS == REG_INSTR) & ~backup;
  wire wr_mem = wr_hit & (AVM_ADDRESS == REG_MEM) & lo_en & ~backup;
  // backup state freezes execution; only reset leaves it
  wire step = wr_hit & (AVM_ADDRESS == REG_CTRL) & lo_en & AVM_WRITEDATA[0] & ~backup;

  // a skipped word still takes its cycle; it changes pc, the skip and arm flags and the chain state
  wire chain_acc = d_la & (chain == CHAIN_ACC);
  wire chain_xy = d_lxy & (chain == CHAIN_XY);
  wire exec = step & ~skip_next & ~chain_acc & ~chain_xy;

  wire [3:0] y_inc = ptr_y + 4'h1;
  wire [3:0] or_val = accum | mem_nibble;
  wire [4:0] rot_val = {accum[0], carry_flag, accum[3:1]};

  wire [3:0] next_accum = (exec & d_la) ? instr[3:0] :
                          (exec & d_or) ? or_val :
                          (exec & d_rot) ? rot_val[3:0] : accum;
  wire next_carry = (exec & d_rot) ? rot_val[4] : carry_flag;
  wire [3:0] next_x = (exec & d_lxy) ? instr[7:4] : ptr_x;
  wire [3:0] next_y = (exec & d_lxy) ? instr[3:0] :
                      (exec & d_inc_y) ? y_inc : ptr_y;
  wire [1:0] next_z = (exec & d_lz) ? instr[1:0] : ptr_z;
  wire next_skip = exec & d_inc_y & (y_inc == 4'h0);
  wire next_backup = exec & d_entry & armed;
  // unarmed entry falls through with no effect, like a no-operation
  wire next_armed = exec & d_arm;
  chain_t next_chain;
  always_comb begin
    next_chain = CHAIN_NONE;
    if (d_la) begin
      next_chain = CHAIN_ACC;
    end else if (d_lxy) begin
      next_chain = CHAIN_XY;
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    if (AVM_ADDRESS == REG_INSTR) begin
      rdata = {22'h00_0000, instr};
    end else if (AVM_ADDRESS == REG_MEM) begin
      rdata = {28'h000_0000, mem_nibble};
    end else if (AVM_ADDRESS == REG_STATE) begin
      rdata = {14'h0000, backup, armed, skip_next, carry_flag, ptr_z, ptr_x, ptr_y, accum};
    end else if (AVM_ADDRESS == REG_PORTS) begin
      rdata = {21'h00_0000, bit_port, port2, port1, port0};
    end else if (AVM_ADDRESS == REG_PC) begin
      rdata = {20'h0_0000, pc};
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      waitreq <= 1'b1;
      AVM_READDATA <= 32'h0000_0000;
    end else if (CLK_EN) begin
      waitreq <= ~req;
      AVM_READDATA <= (AVM_READ & ~ack) ? rdata : AVM_READDATA;
    end
  end
  assign AVM_WAITREQUEST = waitreq;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      instr <= 10'h000;
      mem_nibble <= RST_NIBBLE;
    end else if (CLK_EN) begin
      if (wr_instr & lo_en) begin
        instr[7:0] <= AVM_WRITEDATA[7:0];
      end
      if (wr_instr & hi_en) begin
        instr[9:8] <= AVM_WRITEDATA[9:8];
      end
      if (wr_mem) begin
        mem_nibble <= AVM_WRITEDATA[3:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      accum <= RST_NIBBLE;
      carry_flag <= 1'b0;
      ptr_x <= RST_NIBBLE;
      ptr_y <= RST_NIBBLE;
      ptr_z <= 2'h0;
      pc <= 12'h000;
      skip_next <= 1'b0;
      armed <= 1'b0;
      chain <= CHAIN_NONE;
      backup <= 1'b0;
    end else if (CLK_EN & step) begin
      accum <= next_accum;
      carry_flag <= next_carry;
      ptr_x <= next_x;
      ptr_y <= next_y;
      ptr_z <= next_z;
      pc <= pc + 12'h001;
      skip_next <= next_skip;
      armed <= next_armed;
      chain <= next_chain;
      backup <= next_backup;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      port0 <= RST_NIBBLE;
      port1 <= RST_NIBBLE;
      port2 <= 2'h0;
      bit_port <= 1'b0;
    end else if (CLK_EN & exec) begin
      if (d_wp0) begin
        port0 <= accum;
      end
      if (d_wp1) begin
        port1 <= accum;
      end
      if (d_wp2) begin
        port2 <= accum[1:0];
      end
      if (d_wbit) begin
        bit_port <= accum[0];
      end
    end
  end

  assign PORT_ZERO_PINS = port0;
  assign PORT_ONE_PINS = port1;
  assign PORT_TWO_PINS = port2;
  assign SINGLE_BIT_PORT = bit_port;
  assign BACKUP_STATE = backup;

  // assertions
  property p_inc_wrap;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & exec & d_inc_y) |=> (ptr_y == $past(ptr_y) + 4'h1) && (skip_next == (ptr_y == 4'h0));
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("y increment or wrap skip wrong");

  property p_load_acc;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & exec & d_la) |=> accum == $past(instr[3:0]);
  endproperty
  a_load_acc: assert property (p_load_acc) else $error("accumulator load wrong");

  property p_chain_acc;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & step & chain_acc) |=> accum == $past(accum);
  endproperty
  a_chain_acc: assert property (p_chain_acc) else $error("chained load not skipped");

  property p_load_xy;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & exec & d_lxy) |=> {ptr_x, ptr_y} == $past(instr[7:0]);
  endproperty
  a_load_xy: assert property (p_load_xy) else $error("pointer pair load wrong");

  property p_chain_xy;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & step & chain_xy) |=> {ptr_x, ptr_y} == $past({ptr_x, ptr_y});
  endproperty
  a_chain_xy: assert property (p_chain_xy) else $error("chained pointer load executed");

  property p_load_z;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & exec & d_lz) |=> ptr_z == $past(instr[1:0]) && accum == $past(accum);
  endproperty
  a_load_z: assert property (p_load_z) else $error("bank pointer load wrong");

  property p_nop;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & step & d_nop) |=> pc == $past(pc) + 12'h001 && accum == $past(accum) && port0 == $past(port0);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");

  property p_ports;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & exec & (d_wp0 | d_wp1 | d_wp2 | d_wbit)) |=>
      (port0 == $past(d_wp0 ? accum : port0)) && (port2 == $past(d_wp2 ? accum[1:0] : port2)) &&
      (port1 == $past(d_wp1 ? accum : port1)) &&
      (bit_port == $past(d_wbit ? accum[0] : bit_port));
  endproperty
  a_ports: assert property (p_ports) else $error("port write wrong");

  property p_or;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & exec & d_or) |=> accum == $past(accum | mem_nibble) && $stable(carry_flag);
  endproperty
  a_or: assert property (p_or) else $error("or result wrong");

  sequence s_armed_entry;
    CLK_EN & exec & d_entry & armed;
  endsequence
  property p_backup;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_armed_entry |=> BACKUP_STATE [*2];
  endproperty
  a_backup: assert property (p_backup) else $error("backup state not entered");

  property p_unarmed;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & exec & d_entry & ~armed) |=> ~BACKUP_STATE;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed entry acted");

  property p_rot;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & exec & d_rot) |=> {carry_flag, accum} == {$past(accum[0]), $past(carry_flag), $past(accum[3:1])};
  endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");

  // a word skipped after a wrap must leave the data path alone
  property p_skip;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & step & skip_next) |=> accum == $past(accum) && {ptr_x, ptr_y} == $past({ptr_x, ptr_y});
  endproperty
  a_skip: assert property (p_skip) else $error("skipped word changed state");

  property p_frozen;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & BACKUP_STATE) |=> pc == $past(pc) && accum == $past(accum) && port0 == $past(port0);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved in backup");

  // each access is answered for exactly one cycle
  property p_wait;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (CLK_EN & ~AVM_WAITREQUEST) |=> AVM_WAITREQUEST;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest low too long");
endmodule
`default_nettype wire

// ===== bench/ldop_core_bench.sv
// self-checking bench for the load, output and power instruction group
// assumes one wait cycle per Avalon access and a word that executes on the step write
`timescale 1ns/1ps
`default_nettype none
module ldop_core_bench;
  import ldop_pkg::*;
  logic clk_sys;
  logic sys_rst;
  logic clk_en;
  logic avm_read;
  logic avm_write;
  logic avm_wait;
  logic bit_port;
  logic backup;
  logic [3:0] avm_address;
  logic [3:0] port0;
  logic [3:0] port1;
  logic [1:0] port2;
  logic [31:0] avm_wdata;
  logic [31:0] avm_rdata;
  logic [31:0] rd;
  logic [31:0] saved;
  int n_mismatch = 0;
  int samples_checked = 0;
  int exp_pc = 0;
  int cycles = 0;

  ldop_core u_dut (
    .CLK_SYS(clk_sys),
    .SYS_RST(sys_rst),
    .CLK_EN(clk_en),
    .AVM_ADDRESS(avm_address),
    .AVM_READ(avm_read),
    .AVM_WRITE(avm_write),
    .AVM_WRITEDATA(avm_wdata),
    .AVM_BYTEENABLE(4'hF),
    .AVM_READDATA(avm_rdata),
    .AVM_WAITREQUEST(avm_wait),
    .PORT_ZERO_PINS(port0),
    .PORT_ONE_PINS(port1),
    .PORT_TWO_PINS(port2),
    .SINGLE_BIT_PORT(bit_port),
    .BACKUP_STATE(backup)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // whole run needs well under a thousand cycles; this only cuts a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task print_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low; read data taken at that edge
  task avm(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avm_address <= a;
    avm_write <= wr;
    avm_read <= ~wr;
    avm_wdata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avm_wait !== 1'b0);
    rd = avm_rdata;
    chk("wait cycles", 32'h0000_0002, 32'(n));
    avm_write <= 1'b0;
    avm_read <= 1'b0;
  endtask

  task exec(input logic [9:0] w);
    avm(1'b1, REG_INSTR, 32'(w));
    avm(1'b1, REG_CTRL, 32'h0000_0001);
    exp_pc++;
  endtask

  // skip, arm and backup bits are masked off; they are judged elsewhere
  task state(input logic [3:0] acc, input logic [3:0] y, input logic [3:0] x, input logic [1:0] z,
             input logic cy, input string nm);
    avm(1'b0, REG_STATE, 32'h0000_0000);
    chk(nm, {17'h0_0000, cy, z, x, y, acc}, rd & 32'h0000_7FFF);
  endtask

  task t_reset;
    state(4'h0, 4'h0, 4'h0, 2'h0, 1'b0, "reset state");
    avm(1'b0, REG_PORTS, 32'h0000_0000);
    chk("reset ports", 32'h0000_0000, rd);
    avm(1'b0, 4'hF, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
  endtask

  task t_loads;
    exec({OP_LOAD_ACC_HI, 4'h5});
    exec({OP_LOAD_ACC_HI, 4'h9});
    exec({OP_LOAD_ACC_HI, 4'hA});
    state(4'h5, 4'h0, 4'h0, 2'h0, 1'b0, "acc chain");
    exec(OP_NOP);
    exec({OP_LOAD_ACC_HI, 4'h9});
    state(4'h9, 4'h0, 4'h0, 2'h0, 1'b0, "acc after break");
    exec({OP_LOAD_XY_HI, 8'h3A});
    exec({OP_LOAD_XY_HI, 8'h21});
    state(4'h9, 4'hA, 4'h3, 2'h0, 1'b0, "xy chain");
    exec({OP_LOAD_BANK_HI, 2'h2});
    state(4'h9, 4'hA, 4'h3, 2'h2, 1'b0, "bank load");
  endtask

  task t_inc_y;
    exec({OP_LOAD_XY_HI, 8'h0F});
    exec(OP_INC_Y);
    exec({OP_LOAD_ACC_HI, 4'h7});
    state(4'h9, 4'h0, 4'h0, 2'h2, 1'b0, "wrap skips next");
    exec(OP_INC_Y);
    exec({OP_LOAD_ACC_HI, 4'h3});
    state(4'h3, 4'h1, 4'h0, 2'h2, 1'b0, "no wrap no skip");
  endtask

  task t_rot_or;
    exec(OP_ROT_RIGHT);
    state(4'h1, 4'h1, 4'h0, 2'h2, 1'b1, "rotate one");
    exec(OP_ROT_RIGHT);
    state(4'h8, 4'h1, 4'h0, 2'h2, 1'b1, "rotate two");
    avm(1'b1, REG_MEM, 32'h0000_0003);
    exec(OP_OR_MEM);
    state(4'hB, 4'h1, 4'h0, 2'h2, 1'b1, "or keeps carry");
  endtask

  task t_ports;
    exec(OP_WR_PORT0);
    exec(OP_WR_BIT_PORT);
    exec({OP_LOAD_ACC_HI, 4'h6});
    exec(OP_WR_PORT1);
    exec(OP_WR_PORT2);
    avm(1'b0, REG_PORTS, 32'h0000_0000);
    chk("ports reg", 32'h0000_066B, rd);
    chk("port pins", 32'h0000_066B, {21'h00_0000, bit_port, port2, port1, port0});
    exec({OP_LOAD_ACC_HI, 4'hE});
    exec(OP_WR_BIT_PORT);
    avm(1'b0, REG_PORTS, 32'h0000_0000);
    chk("bit port only bit0", 32'h0000_026B, {21'h00_0000, bit_port, port2, port1, port0});
  endtask

  task t_nop;
    avm(1'b0, REG_STATE, 32'h0000_0000);
    saved = rd;
    exec(OP_NOP);
    avm(1'b0, REG_STATE, 32'h0000_0000);
    chk("nop state", saved, rd);
    avm(1'b0, REG_PC, 32'h0000_0000);
    chk("pc count", 32'(exp_pc), rd & 32'h0000_0FFF);
  endtask

  // a frozen core must neither answer a pending step nor execute it
  task t_clk_en;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    avm_address <= REG_CTRL;
    avm_write <= 1'b1;
    avm_wdata <= 32'h0000_0001;
    repeat (4) begin
      @(posedge clk_sys);
      chk("frozen waitrequest", 32'h0000_0001, 32'(avm_wait));
    end
    clk_en <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (avm_wait !== 1'b0);
    avm_write <= 1'b0;
    exp_pc++;
    avm(1'b0, REG_PC, 32'h0000_0000);
    chk("pc after freeze", 32'(exp_pc), rd & 32'h0000_0FFF);
  endtask

  task t_backup;
    exec(OP_BACKUP_ENTRY);
    state(4'hE, 4'h1, 4'h0, 2'h2, 1'b1, "unarmed entry state");
    chk("unarmed backup pin", 32'h0000_0000, 32'(backup));
    exec(OP_BACKUP_ARM);
    exec(OP_BACKUP_ENTRY);
    avm(1'b0, REG_STATE, 32'h0000_0000);
    chk("armed backup pin", 32'h0000_0001, 32'(backup));
    // in backup the step write is ignored, so the program counter stays
    exec({OP_LOAD_ACC_HI, 4'h0});
    exp_pc--;
    state(4'hE, 4'h1, 4'h0, 2'h2, 1'b1, "frozen in backup");
    avm(1'b0, REG_PC, 32'h0000_0000);
    chk("pc frozen", 32'(exp_pc), rd & 32'h0000_0FFF);
  endtask

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    avm_read = 1'b0;
    avm_write = 1'b0;
    avm_address = 4'h0;
    avm_wdata = 32'h0000_0000;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_loads();
    t_inc_y();
    t_rot_or();
    t_ports();
    t_nop();
    t_clk_en();
    t_backup();
    print_verdict();
  end
endmodule
`default_nettype wire
